//--- design/ipr_pkg.sv
// Purpose: Shared constants and types for the interrupt priority bank.
// Assumes: 32-bit Avalon-MM slave, registers 16 bits wide in low lanes.
// Notes: Every offset, field position and reset value lives here.

`default_nettype none

package ipr_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int NUM_REGS = 6;
    localparam int FIELDS_PER_REG = 4;
    localparam int NUM_FIELDS = NUM_REGS * FIELDS_PER_REG;
    localparam int ADDR_W = 5;
    localparam int PRIO_W = 3;
    localparam int REG_W = 16;

    // Byte addresses of the six priority registers
    localparam logic [ADDR_W-1:0] OFS_PRIORITY_CTRL_9 = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_PRIORITY_CTRL_10 = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_PRIORITY_CTRL_11 = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_PRIORITY_CTRL_12 = 5'h0C;
    localparam logic [ADDR_W-1:0] OFS_PRIORITY_CTRL_13 = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_PRIORITY_CTRL_14 = 5'h14;

    // ************************************************************
    // Field layout
    // ************************************************************
    // Field f of a register sits at bits f*4+2 .. f*4 (2-0,6-4,10-8,14-12)
    localparam int FIELD_STRIDE = 4;
    localparam int FLD_LO = 0;   // bits 2-0
    localparam int FLD_ML = 1;   // bits 6-4
    localparam int FLD_MH = 2;   // bits 10-8
    localparam int FLD_HI = 3;   // bits 14-12

    // Implemented fields per register, bit f set when field f exists
    localparam logic [NUM_REGS-1:0][FIELDS_PER_REG-1:0] IMPL_MAP = {
        4'hF,   // priority_ctrl_14
        4'hF,   // priority_ctrl_13
        4'hF,   // priority_ctrl_12
        4'hD,   // priority_ctrl_11, bits 6-4 unimplemented
        4'hF,   // priority_ctrl_10
        4'hF    // priority_ctrl_9
    };

    // Every implemented field powers up at priority 4
    localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h4;
    localparam logic [PRIO_W-1:0] PRIO_OFF = 3'h0;
    localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ACK = 2'b10
    } ipr_state_e;

    typedef struct packed {
        ipr_state_e state;
        logic [31:0] rdata;
    } ipr_bus_s;

    typedef struct packed {
        logic [PRIO_W-1:0] value;
    } ipr_field_s;

    // Priorities handed to the arbiter, 0 = source disabled
    typedef struct packed {
        logic [PRIO_W-1:0] capture5_prio;
        logic [PRIO_W-1:0] capture4_prio;
        logic [PRIO_W-1:0] capture3_prio;
        logic [PRIO_W-1:0] dma_chan3_prio;
        logic [PRIO_W-1:0] compare7_prio;
        logic [PRIO_W-1:0] compare6_prio;
        logic [PRIO_W-1:0] compare5_prio;
        logic [PRIO_W-1:0] capture6_prio;
        logic [PRIO_W-1:0] timer6_prio;
        logic [PRIO_W-1:0] dma_chan4_prio;
        logic [PRIO_W-1:0] compare8_prio;
        logic [PRIO_W-1:0] timer8_prio;
        logic [PRIO_W-1:0] i2c_b_master_prio;
        logic [PRIO_W-1:0] i2c_b_slave_prio;
        logic [PRIO_W-1:0] timer7_prio;
        logic [PRIO_W-1:0] can_b_rx_prio;
        logic [PRIO_W-1:0] ext_irq4_prio;
        logic [PRIO_W-1:0] ext_irq3_prio;
        logic [PRIO_W-1:0] timer9_prio;
        logic [PRIO_W-1:0] codec_if_error_prio;
        logic [PRIO_W-1:0] quad_encoder_prio;
        logic [PRIO_W-1:0] pulse_width_prio;
        logic [PRIO_W-1:0] can_b_event_prio;
    } ipr_prio_s;

endpackage

`default_nettype wire

//--- design/ipr_field.sv
// Purpose: One 3-bit read/write priority field.
// Assumes: Write strobe already qualified by address and byte enable.
// Notes: An unimplemented field holds zero and ignores writes.

`timescale 1ns/1ps
`default_nettype none

module ipr_field #(
    parameter bit IMPL = 1'b1
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic wr_en,
    input wire logic [ipr_pkg::PRIO_W-1:0] wr_data,
    output logic [ipr_pkg::PRIO_W-1:0] value
);

    ipr_pkg::ipr_field_s state_r;
    ipr_pkg::ipr_field_s state_nxt;

    // Next value: load on write only where the field exists
    always_comb begin
        state_nxt = state_r;
        if (!IMPL) begin
            state_nxt.value = ipr_pkg::PRIO_OFF;
        end else if (wr_en) begin
            state_nxt.value = wr_data;
        end
    end

    // Synchronous reset loads priority 4, or zero when absent
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state_r.value <= IMPL ? ipr_pkg::PRIO_RESET
                                  : ipr_pkg::PRIO_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign value = state_r.value;

endmodule

`default_nettype wire

//--- design/ipr_regs.sv
// Purpose: Bank of six interrupt priority control registers on Avalon-MM.
// Assumes: Master holds its request until it sees waitrequest low.
// Notes: Each access completes in two cycles; data out of flip-flops.
//        Unmapped addresses read zero and drop writes, with no error.

`timescale 1ns/1ps
`default_nettype none

module ipr_regs (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [ipr_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output ipr_pkg::ipr_prio_s prio
);

    // ************************************************************
    // Declarations
    // ************************************************************
    localparam int NR = ipr_pkg::NUM_REGS;
    localparam int NF = ipr_pkg::FIELDS_PER_REG;
    localparam int PW = ipr_pkg::PRIO_W;
    localparam int FS = ipr_pkg::FIELD_STRIDE;

    // Bus state, one packed struct registered as a whole
    ipr_pkg::ipr_bus_s bus_r;
    ipr_pkg::ipr_bus_s bus_nxt;

    // Field values and decode helpers
    logic [NR-1:0][NF-1:0][PW-1:0] fld_val;
    logic [NR-1:0] reg_sel;
    logic addr_ok;
    logic wr_commit;
    logic [NR-1:0][ipr_pkg::REG_W-1:0] reg_view;
    logic [NR-1:0] wr_reg;
    logic [ipr_pkg::REG_W-1:0] rd_word;

    // ************************************************************
    // Address decode
    // ************************************************************
    // Offsets are word aligned; a misaligned or unlisted address misses.
    // The select is one-hot or empty, never two registers at once.
    always_comb begin
        reg_sel = '0;
        case (avs_address)
            ipr_pkg::OFS_PRIORITY_CTRL_9: reg_sel[0] = 1'b1;
            ipr_pkg::OFS_PRIORITY_CTRL_10: reg_sel[1] = 1'b1;
            ipr_pkg::OFS_PRIORITY_CTRL_11: reg_sel[2] = 1'b1;
            ipr_pkg::OFS_PRIORITY_CTRL_12: reg_sel[3] = 1'b1;
            ipr_pkg::OFS_PRIORITY_CTRL_13: reg_sel[4] = 1'b1;
            ipr_pkg::OFS_PRIORITY_CTRL_14: reg_sel[5] = 1'b1;
            default: reg_sel = '0;
        endcase
    end

    // Any hit at all; a miss reads zero and writes nothing
    assign addr_ok = |reg_sel;

    // Write lands only at the edge where waitrequest is seen low.
    // Gating on ACK keeps a write from landing twice in one access.
    assign wr_commit = (bus_r.state == ipr_pkg::ST_ACK) && avs_write;

    // Per-register write strobes; a miss raises none of them
    assign wr_reg = wr_commit ? reg_sel : '0;

    // ************************************************************
    // Priority fields
    // ************************************************************
    // Each field sits in the byte lane that its bits fall into:
    // lane 0 feeds fields LO and ML, lane 1 fields MH and HI.
    // Lanes 2 and 3 hold no fields, so their enables are ignored.
    for (genvar r = 0; r < NR; r++) begin : g_reg
        for (genvar f = 0; f < NF; f++) begin : g_fld
            ipr_field #(
                .IMPL(ipr_pkg::IMPL_MAP[r][f])
            ) u_fld (
                .core_clk(core_clk),
                .rstn(rstn),
                .wr_en(wr_reg[r] && avs_byteenable[f/2]),
                .wr_data(avs_writedata[f*FS +: PW]),
                .value(fld_val[r][f])
            );
        end
    end

    // Register images as software reads them; gaps read as zero.
    // Unimplemented fields are held at zero inside the field itself.
    always_comb begin
        reg_view = '0;
        for (int r = 0; r < NR; r++) begin
            for (int f = 0; f < NF; f++) begin
                reg_view[r][f*FS +: PW] = fld_val[r][f];
            end
        end
    end

    // Read mux; the select is one-hot, so OR-ing the gated images is safe
    always_comb begin
        rd_word = '0;
        for (int r = 0; r < NR; r++) begin
            if (reg_sel[r]) begin
                rd_word = rd_word | reg_view[r];
            end
        end
    end

    // ************************************************************
    // Avalon-MM slave
    // ************************************************************
    // Cycle 0 sees the request and registers read data; cycle 1 answers.
    // One fixed wait state keeps read data in a flop at the cost of speed.
    // Walk of one access:
    //   cycle 0: request up, waitrequest high, state IDLE
    //   edge E0: read word captured, state moves to ACK
    //   cycle 1: waitrequest low, read data stand on the bus
    //   edge E1: write lands in its fields, state back to IDLE
    // A request still held at E1 starts afresh, two cycles per access.
    always_comb begin
        bus_nxt = bus_r;
        case (bus_r.state)
            ipr_pkg::ST_IDLE: begin
                if (avs_read || avs_write) begin
                    bus_nxt.state = ipr_pkg::ST_ACK;
                    bus_nxt.rdata = ipr_pkg::RDATA_UNMAPPED;
                    if (avs_read && addr_ok) begin
                        bus_nxt.rdata = {16'h0000, rd_word};
                    end
                end
            end
            // Answer given this cycle; back to idle at the edge
            ipr_pkg::ST_ACK: begin
                bus_nxt.state = ipr_pkg::ST_IDLE;
            end
            // Illegal codes fall back to idle rather than hang the bus
            default: begin
                bus_nxt.state = ipr_pkg::ST_IDLE;
            end
        endcase
    end

    // Bus state registers; reset parks the slave idle with zero read data
    // so that no stale word is shown after a reset in mid-run.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            bus_r.state <= ipr_pkg::ST_IDLE;
            bus_r.rdata <= ipr_pkg::RDATA_UNMAPPED;
        end else begin
            bus_r <= bus_nxt;
        end
    end

    // Unmapped reads return zero; unmapped writes are dropped quietly.
    // Waitrequest is combinational: low whenever no request stands, and
    // high in the first cycle of each access, so no access ends early.
    assign avs_readdata = bus_r.rdata;
    assign avs_waitrequest = (avs_read || avs_write) &&
                             (bus_r.state != ipr_pkg::ST_ACK);

    // ************************************************************
    // Priority outputs to the arbiter
    // ************************************************************
    // Map of the six words, bits 31-16 and 15,11,7,3 always read zero:
    //   0x00 ctrl_9 : capture5, capture4, capture3, dma_chan3
    //   0x04 ctrl_10: compare7, compare6, compare5, capture6
    //   0x08 ctrl_11: timer6, dma_chan4, (none), compare8
    //   0x0C ctrl_12: timer8, i2c_b_master, i2c_b_slave, timer7
    //   0x10 ctrl_13: can_b_rx, ext_irq4, ext_irq3, timer9
    //   0x14 ctrl_14: codec_if_error, quad_encoder, pulse_width, can_b_event
    // Fields are listed from bits 14-12 down to bits 2-0.
    // A zero field disables its source; the arbiter ranks 7 highest.
    // Each output follows its flop, so it changes one edge after a write.

    // priority_ctrl_9
    assign prio.capture5_prio = fld_val[0][ipr_pkg::FLD_HI];
    assign prio.capture4_prio = fld_val[0][ipr_pkg::FLD_MH];
    assign prio.capture3_prio = fld_val[0][ipr_pkg::FLD_ML];
    assign prio.dma_chan3_prio = fld_val[0][ipr_pkg::FLD_LO];

    // priority_ctrl_10
    assign prio.compare7_prio = fld_val[1][ipr_pkg::FLD_HI];
    assign prio.compare6_prio = fld_val[1][ipr_pkg::FLD_MH];
    assign prio.compare5_prio = fld_val[1][ipr_pkg::FLD_ML];
    assign prio.capture6_prio = fld_val[1][ipr_pkg::FLD_LO];

    // priority_ctrl_11
    assign prio.timer6_prio = fld_val[2][ipr_pkg::FLD_HI];
    assign prio.dma_chan4_prio = fld_val[2][ipr_pkg::FLD_MH];
    assign prio.compare8_prio = fld_val[2][ipr_pkg::FLD_LO];

    // priority_ctrl_12
    assign prio.timer8_prio = fld_val[3][ipr_pkg::FLD_HI];
    assign prio.i2c_b_master_prio = fld_val[3][ipr_pkg::FLD_MH];
    assign prio.i2c_b_slave_prio = fld_val[3][ipr_pkg::FLD_ML];
    assign prio.timer7_prio = fld_val[3][ipr_pkg::FLD_LO];

    // priority_ctrl_13
    assign prio.can_b_rx_prio = fld_val[4][ipr_pkg::FLD_HI];
    assign prio.ext_irq4_prio = fld_val[4][ipr_pkg::FLD_MH];
    assign prio.ext_irq3_prio = fld_val[4][ipr_pkg::FLD_ML];
    assign prio.timer9_prio = fld_val[4][ipr_pkg::FLD_LO];

    // priority_ctrl_14
    assign prio.codec_if_error_prio = fld_val[5][ipr_pkg::FLD_HI];
    assign prio.quad_encoder_prio = fld_val[5][ipr_pkg::FLD_MH];
    assign prio.pulse_width_prio = fld_val[5][ipr_pkg::FLD_ML];
    assign prio.can_b_event_prio = fld_val[5][ipr_pkg::FLD_LO];

endmodule

`default_nettype wire

//--- verification/ipr_regs_checker.sv
// Purpose: Concurrent checks on the priority bank's bus and field outputs.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Sees only the ports of ipr_regs; attached by bind below.

`timescale 1ns/1ps
`default_nettype none

module ipr_regs_checker (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [ipr_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire ipr_pkg::ipr_prio_s prio
);
    // ************************************************************
    // Helpers
    // ************************************************************
    // A write completes in the cycle its wait state has ended
    logic wr_done;
    assign wr_done = avs_write && !avs_waitrequest;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    // ************************************************************
    // Field and bus properties
    // ************************************************************
    // Each checked field follows its lane's bits of the completed write one edge later
    a_compare6_write: assert property (wr_done && avs_byteenable[1] &&
        avs_address == ipr_pkg::OFS_PRIORITY_CTRL_10
        |=> prio.compare6_prio == $past(avs_writedata[10:8]))
        else $error("compare6 field did not take written value");
    a_i2c_master_write: assert property (wr_done && avs_byteenable[1] &&
        avs_address == ipr_pkg::OFS_PRIORITY_CTRL_12
        |=> prio.i2c_b_master_prio == $past(avs_writedata[10:8]))
        else $error("i2c master field did not take written value");
    a_ext_irq4_write: assert property (wr_done && avs_byteenable[1] &&
        avs_address == ipr_pkg::OFS_PRIORITY_CTRL_13
        |=> prio.ext_irq4_prio == $past(avs_writedata[10:8]))
        else $error("ext irq4 field did not take written value");
    a_timer9_write: assert property (wr_done && avs_byteenable[0] &&
        avs_address == ipr_pkg::OFS_PRIORITY_CTRL_13
        |=> prio.timer9_prio == $past(avs_writedata[2:0]))
        else $error("timer9 field did not take written value");
    a_quad_enc_write: assert property (wr_done && avs_byteenable[1] &&
        avs_address == ipr_pkg::OFS_PRIORITY_CTRL_14
        |=> prio.quad_encoder_prio == $past(avs_writedata[10:8]))
        else $error("quad encoder field did not take written value");
    // Reset must land priority 4, so no disable here
    a_reset_prio_four: assert property (disable iff (1'b0) !rstn
        |=> prio.timer9_prio == 3'h4 && prio.compare6_prio == 3'h4)
        else $error("field not at priority 4 after reset");
    a_unimpl_read_zero: assert property (avs_read && !avs_waitrequest
        |-> (avs_readdata & 32'hFFFF_8888) == 32'h0000_0000)
        else $error("unimplemented read bits not zero");
    a_ctrl11_gap_zero: assert property (avs_read && !avs_waitrequest &&
        avs_address == ipr_pkg::OFS_PRIORITY_CTRL_11
        |-> avs_readdata[6:4] == 3'h0)
        else $error("unimplemented ctrl_11 field not zero");
    // Fields must hold when no write completes
    a_fields_hold: assert property (!wr_done |=> $stable(prio))
        else $error("priority fields changed without a write");
endmodule

bind ipr_regs ipr_regs_checker ipr_regs_checker_inst (
    .core_clk(core_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .prio(prio)
);

`default_nettype wire

//--- verification/ipr_regs_tb.sv
// Purpose: Self-checking bench for the priority bank over Avalon-MM.
// Assumes: The slave answers by waitrequest; no access length is assumed.
// Notes: Waitrequest and read data are sampled at the rising edge.

`timescale 1ns/1ps
`default_nettype none

module ipr_regs_tb;
    logic core_clk, rstn, avs_read, avs_write, avs_waitrequest;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0] avs_byteenable;
    ipr_pkg::ipr_prio_s prio;
    int bad_count, samples_checked;

    ipr_regs ipr_regs_inst (.core_clk(core_clk), .rstn(rstn),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .prio(prio));

    // 20 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One access; an edge passes first so no strobe is set twice at once.
    // At the edge the slave still shows the cycle just ended, so the
    // request is dropped at the very edge where waitrequest is seen low.
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        @(posedge core_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        avs_byteenable <= be;
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Hang guard, far beyond the hundred or so cycles of the tests
    initial begin
        repeat (3000) @(posedge core_clk);
        bad_count++;
        $display("watchdog expired");
        summarize();
    end

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        rstn = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 5'h00;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'h0;
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, 5'(i * 4), 32'h0, 4'h0);
            check("reset image", q, (i == 2) ? 32'h4404 : 32'h4444);
        end
        check("prio reset", 32'(prio == {23{3'h4}}), 32'h1);
        $display("test reset images done");
        // All ones: unimplemented bits must stay zero
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, 5'(i * 4), 32'hFFFF_FFFF, 4'hF);
            bus(1'b0, 5'(i * 4), 32'h0, 4'h0);
            check("all ones", q, (i == 2) ? 32'h7707 : 32'h7777);
        end
        check("compare6 top", 32'(prio.compare6_prio), 32'h7);
        check("prio all ones", 32'(prio == {23{3'h7}}), 32'h1);
        $display("test write ones done");
        // Lowest, highest and disabled codes, one code per field
        bus(1'b1, 5'h0C, 32'h0000_0100, 4'h3);
        @(negedge core_clk);
        check("i2c master", 32'(prio.i2c_b_master_prio), 32'h1);
        bus(1'b1, 5'h10, 32'h0000_0700, 4'h3);
        @(negedge core_clk);
        check("ext irq4", 32'(prio.ext_irq4_prio), 32'h7);
        check("timer9 off", 32'(prio.timer9_prio), 32'h0);
        bus(1'b1, 5'h14, 32'h0000_0000, 4'h3);
        @(negedge core_clk);
        check("quad enc off", 32'(prio.quad_encoder_prio), 32'h0);
        bus(1'b1, 5'h04, 32'h0000_0000, 4'h3);
        @(negedge core_clk);
        check("compare6 off", 32'(prio.compare6_prio), 32'h0);
        $display("test field codes done");
        // Low lane only: the upper byte fields must hold
        bus(1'b1, 5'h10, 32'h0000_0303, 4'h1);
        bus(1'b0, 5'h10, 32'h0, 4'h0);
        check("low lane", q, 32'h0000_0703);
        // Unmapped and misaligned places are silent
        bus(1'b1, 5'h18, 32'hFFFF_FFFF, 4'hF);
        bus(1'b0, 5'h18, 32'h0, 4'h0);
        check("unmapped", q, 32'h0);
        bus(1'b0, 5'h11, 32'h0, 4'h0);
        check("misaligned", q, 32'h0);
        bus(1'b0, 5'h10, 32'h0, 4'h0);
        check("after unmapped", q, 32'h0000_0703);
        $display("test lanes and unmapped done");
        // Second reset in mid-run
        @(posedge core_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        bus(1'b0, 5'h0C, 32'h0, 4'h0);
        check("re-reset", q, 32'h4444);
        $display("test second reset done");
        summarize();
    end
endmodule

`default_nettype wire
